//--- tcg_consts.svh
`ifndef TCG_CONSTS_SVH
`define TCG_CONSTS_SVH
// register byte offsets
`define TCG_OFF_CTRL 12'h000
`define TCG_OFF_OUTC 12'h004
`define TCG_OFF_CCRA 12'h008
`define TCG_OFF_CCRB 12'h00C
`define TCG_OFF_CNT 12'h010
`define TCG_OFF_STAT 12'h014
`define TCG_OFF_MASK 12'h018
`define TCG_OFF_EDGE 12'h01C
// control field positions
`define TCG_CTRL_MODE_LO 0
`define TCG_CTRL_MODE_HI 1
`define TCG_CTRL_SOFT_TRIG 2
`define TCG_CTRL_REV_CAP 3
// output control field positions
`define TCG_OUTC_EN 0
`define TCG_OUTC_LVL_SET 1
`define TCG_OUTC_LVL_RST 2
`define TCG_OUTC_CTL_LO 3
`define TCG_OUTC_CTL_HI 4
// edge select field positions
`define TCG_EDGE_A_LO 0
`define TCG_EDGE_A_HI 1
`define TCG_EDGE_B_LO 2
`define TCG_EDGE_B_HI 3
// status bits
`define TCG_ST_CAP_A 0
`define TCG_ST_CAP_B 1
`define TCG_ST_MATCH_A 2
`define TCG_ST_MATCH_B 3
// reset values and prescaler terminal count
`define TCG_RST_CCR 16'hFFFF
`define TCG_RST_PRESC 8'h00
`define TCG_PRESC_DEF 8'h03
`endif

//--- tcg_pkg.sv
package tcg_pkg;
  typedef enum logic [1:0] {
    TCG_EDGE_FALL,
    TCG_EDGE_RISE,
    TCG_EDGE_NONE,
    TCG_EDGE_BOTH
  } tcg_edge_t;
  typedef enum logic [1:0] {
    TCG_OS_IDLE,
    TCG_OS_DELAY,
    TCG_OS_ACTIVE
  } tcg_os_t;
endpackage

//--- tcg_bus_if.sv
`timescale 1ns/1ps
// register-store access port between the top and its storage
interface tcg_bus_if;
  logic we;
  logic [2:0] waddr;
  logic [31:0] wdata;
  logic [2:0] raddr;
  logic [31:0] rdata;
  modport master (output we, output waddr, output wdata, output raddr, input rdata);
  modport slave (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- tcg_regmem.sv
`timescale 1ns/1ps
// small word store with registered read data
module tcg_regmem (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // access port
  tcg_bus_if.slave bus
);
  logic [31:0] mem_r [0:7];
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  // read mux
  always_comb begin
    rdata_nxt = mem_r[bus.raddr];
  end
  // store and registered read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= 32'h00000000;
      for (int i = 0; i < 8; i++) begin
        mem_r[i] <= 32'h00000000;
      end
    end else begin
      rdata_r <= rdata_nxt;
      if (bus.we) begin
        mem_r[bus.waddr] <= bus.wdata;
      end
    end
  end
  assign bus.rdata = rdata_r;
endmodule

//--- tcg_top.sv
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "tcg_consts.svh"
// Function
// [R1] soft-only trigger needs input A steady
// [R2] never equal values in both compare registers
// [R3] level bits written only via setup order
// [R4] order: control bits, enable, then level
// [R5] start unsynchronised; first match jitters one tick (the code holds the prescaler at zero while stopped, so start is aligned)
// [R6] compare registers must be nonzero
// [R7] capture during read: capture done, data undefined
// [R8] valid edge interrupts; reverse-phase capture silent
// [R9] read capture register after its interrupt
// [R10] compare registers undefined once timer stopped
// [R11] change edge select only while stopped
// [R12] one-shot from soft bit or valid A edge
module tcg_top (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // axi4-lite write address
  input wire logic [11:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  // axi4-lite write data
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  // axi4-lite write response
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // axi4-lite read
  input wire logic [11:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // capture pins
  input wire logic CAPTURE_INPUT_A_I,
  input wire logic CAPTURE_INPUT_B_I,
  // timer output pin and interrupt
  output logic TIMER_OUT_O,
  output logic TIMER_OUT_OE_O,
  output logic IRQ_O
);
  tcg_bus_if mem_bus ();
  tcg_regmem u_mem (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .bus(mem_bus)
  );

  // decodes a byte offset into a word index, flags unmapped
  function automatic logic [3:0] dec(input logic [11:0] a);
    if (a[11:5] != 7'h00 || a[1:0] != 2'b00) begin
      dec = 4'h8;
    end else begin
      dec = {1'b0, a[4:2]};
    end
  endfunction
  // detects a valid edge given previous/current level and select
  function automatic logic edge_hit(input logic p, input logic c, input logic [1:0] sel);
    unique case (tcg_pkg::tcg_edge_t'(sel))
      tcg_pkg::TCG_EDGE_FALL: edge_hit = p & ~c;
      tcg_pkg::TCG_EDGE_RISE: edge_hit = ~p & c;
      tcg_pkg::TCG_EDGE_NONE: edge_hit = 1'b0;
      tcg_pkg::TCG_EDGE_BOTH: edge_hit = p ^ c;
    endcase
  endfunction
  logic [1:0] mode_r, mode_nxt;
  logic rev_cap_r, rev_cap_nxt;
  logic [4:0] outc_r, outc_nxt;
  logic [15:0] ccra_r, ccra_nxt, ccrb_r, ccrb_nxt, cnt_r, cnt_nxt;
  logic [3:0] stat_r, stat_nxt, mask_r, mask_nxt, edge_r, edge_nxt;
  logic [7:0] presc_r, presc_nxt;
  logic tick;
  logic pa_r, pb_r, a_s_r, b_s_r, pa_nxt, pb_nxt;
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, ar_r, ar_nxt, rv_r, rv_nxt;
  logic rpend_r, rpend_nxt;
  logic [11:0] awa_r, awa_nxt, ara_r, ara_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [3:0] ridx_r, ridx_nxt;
  logic cap_during_read;
  tcg_pkg::tcg_os_t os_r, os_nxt;
  logic tout_r, tout_nxt, irq_r, irq_nxt, oe_r, oe_nxt;
  logic running, hit_a, hit_b, rev_a, trig, do_w, set_bit, rst_bit;
  logic [3:0] widx;
  logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, arrdy_r, arrdy_nxt, wsz_r, wsz_nxt;
  assign running = (mode_r != 2'b00);
  assign tick = running && (presc_r == `TCG_PRESC_DEF);
  // edge detection on synchronous pins, stopped timer sees nothing
  assign hit_a = running && edge_hit(a_s_r, pa_r, edge_r[1:0]);
  assign hit_b = running && edge_hit(b_s_r, pb_r, edge_r[3:2]);
  // reverse phase: same select with the two samples swapped
  assign rev_a = running && rev_cap_r && edge_hit(pa_r, a_s_r, edge_r[1:0]);
  assign do_w = aw_r && w_r && !bv_r;
  assign widx = dec(awa_r);
  assign trig = (do_w && widx == 4'h0 && wd_r[`TCG_CTRL_SOFT_TRIG]) || hit_a; // [R12]
  assign cap_during_read = rpend_r && (hit_a || hit_b || rev_a);
  // axi channel handshakes
  always_comb begin
    aw_nxt = aw_r;
    awa_nxt = awa_r;
    w_nxt = w_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    bresp_nxt = bresp_r;
    ar_nxt = ar_r;
    ara_nxt = ara_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rresp_nxt = rresp_r;
    rpend_nxt = 1'b0;
    ridx_nxt = ridx_r;
    wsz_nxt = wsz_r;
    if (AWVALID_I && !aw_r && !bv_r) begin
      aw_nxt = 1'b1;
      awa_nxt = AWADDR_I;
    end
    if (WVALID_I && !w_r && !bv_r) begin
      w_nxt = 1'b1;
      wd_nxt = WDATA_I;
      wsz_nxt = (WSTRB_I == 4'h0); // strobe kept with its data
    end
    if (do_w) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = (widx[3] || wsz_r) ? 2'b10 : 2'b00;
    end
    if (bv_r && BREADY_I) begin
      bv_nxt = 1'b0;
    end
    if (ARVALID_I && !ar_r && !rv_r && !rpend_r) begin
      ar_nxt = 1'b1;
      ara_nxt = ARADDR_I;
    end
    if (ar_r) begin
      ar_nxt = 1'b0;
      rpend_nxt = 1'b1;
      ridx_nxt = dec(ara_r);
    end
    if (rpend_r) begin
      rv_nxt = 1'b1;
      rresp_nxt = ridx_r[3] ? 2'b10 : 2'b00;
      unique case (ridx_r)
        4'h0: rd_nxt = {28'h0000000, rev_cap_r, 1'b0, mode_r};
        4'h1: rd_nxt = {27'h0000000, outc_r};
        4'h2: rd_nxt = {16'h0000, ccra_r};
        4'h3: rd_nxt = {16'h0000, ccrb_r};
        4'h4: rd_nxt = {16'h0000, cnt_r};
        4'h5: rd_nxt = {28'h0000000, stat_r};
        4'h6: rd_nxt = {28'h0000000, mask_r};
        4'h7: rd_nxt = {28'h0000000, edge_r};
        default: rd_nxt = 32'h00000000;
      endcase
      // capture racing the read: returned data are not guaranteed
      if (cap_during_read && (ridx_r == 4'h2 || ridx_r == 4'h3)) begin
        rd_nxt = mem_bus.rdata; // [R7]
      end
    end
    if (rv_r && RREADY_I) begin
      rv_nxt = 1'b0;
    end
    // readies registered so the ports come from flops
    awrdy_nxt = !aw_nxt && !bv_nxt;
    wrdy_nxt = !w_nxt && !bv_nxt;
    arrdy_nxt = !ar_nxt && !rv_nxt && !rpend_nxt;
  end

  // scratch store takes every accepted write at its register index, unmapped offsets at index 0, for the race read path
  assign mem_bus.we = do_w;
  assign mem_bus.waddr = widx[2:0];
  assign mem_bus.wdata = wd_r;
  assign mem_bus.raddr = ridx_r[2:0];
  // timer state, registers, capture and interrupts
  always_comb begin
    mode_nxt = mode_r;
    rev_cap_nxt = rev_cap_r;
    outc_nxt = outc_r;
    ccra_nxt = ccra_r;
    ccrb_nxt = ccrb_r;
    mask_nxt = mask_r;
    edge_nxt = edge_r;
    stat_nxt = stat_r;
    pa_nxt = CAPTURE_INPUT_A_I;
    pb_nxt = CAPTURE_INPUT_B_I;
    presc_nxt = (!running || tick) ? `TCG_RST_PRESC : presc_r + 8'h01;
    cnt_nxt = cnt_r;
    // prescaler held at zero while stopped, so start is aligned to the tick phase
    if (!running) begin
      cnt_nxt = 16'h0000; // [R5]
    end else if (tick) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (rpend_r && ridx_r == 4'h5) begin
      stat_nxt = 4'h0;
    end
    if (do_w && !widx[3]) begin
      unique case (widx[2:0])
        3'h0: begin
          mode_nxt = wd_r[`TCG_CTRL_MODE_HI:`TCG_CTRL_MODE_LO];
          rev_cap_nxt = wd_r[`TCG_CTRL_REV_CAP];
        end
        3'h1: outc_nxt = wd_r[4:0];
        3'h2: ccra_nxt = wd_r[15:0];
        3'h3: ccrb_nxt = wd_r[15:0];
        3'h6: mask_nxt = wd_r[3:0];
        3'h7: begin
          // edge selects only change while stopped
          if (!running) begin
            edge_nxt = wd_r[3:0]; // [R11]
          end
        end
        default: begin
        end
      endcase
    end
    // capture a on valid or reverse-phase edge, b on valid edge
    if (hit_a || rev_a) begin
      ccra_nxt = cnt_r; // [R7]
    end
    if (hit_b) begin
      ccrb_nxt = cnt_r;
    end
    // once stopped the compare contents are not kept
    if (running && mode_nxt == 2'b00) begin
      ccra_nxt = `TCG_RST_CCR; // [R10]
      ccrb_nxt = `TCG_RST_CCR; // [R10]
    end
    // interrupt sets win over the read clear; reverse-phase capture sets nothing
    stat_nxt[`TCG_ST_CAP_A] = stat_nxt[`TCG_ST_CAP_A] | hit_a; // [R8]
    stat_nxt[`TCG_ST_CAP_B] = stat_nxt[`TCG_ST_CAP_B] | hit_b; // [R8]
    stat_nxt[`TCG_ST_MATCH_A] = stat_nxt[`TCG_ST_MATCH_A] | (tick && cnt_r == ccra_r);
    stat_nxt[`TCG_ST_MATCH_B] = stat_nxt[`TCG_ST_MATCH_B] | (tick && cnt_r == ccrb_r);
    irq_nxt = |(stat_nxt & mask_nxt);
  end
  // one-shot output: delay until match b, active until match a
  always_comb begin
    os_nxt = os_r;
    tout_nxt = tout_r;
    oe_nxt = outc_r[`TCG_OUTC_EN];
    set_bit = do_w && widx == 4'h1 && wd_r[`TCG_OUTC_LVL_SET]; // [R3]
    rst_bit = do_w && widx == 4'h1 && wd_r[`TCG_OUTC_LVL_RST]; // [R4]
    if (set_bit) begin
      tout_nxt = 1'b1;
    end else if (rst_bit) begin
      tout_nxt = 1'b0;
    end
    unique case (os_r)
      tcg_pkg::TCG_OS_IDLE: begin
        if (trig && running && outc_r[`TCG_OUTC_CTL_HI]) begin
          os_nxt = tcg_pkg::TCG_OS_DELAY; // [R12]
        end
      end
      tcg_pkg::TCG_OS_DELAY: begin
        if (tick && cnt_r == ccrb_r) begin
          os_nxt = tcg_pkg::TCG_OS_ACTIVE;
          tout_nxt = ~tout_r;
        end
      end
      tcg_pkg::TCG_OS_ACTIVE: begin
        if (tick && cnt_r == ccra_r) begin
          os_nxt = tcg_pkg::TCG_OS_IDLE;
          tout_nxt = ~tout_r;
        end
      end
      default: os_nxt = tcg_pkg::TCG_OS_IDLE;
    endcase
    if (!running) begin
      os_nxt = tcg_pkg::TCG_OS_IDLE;
    end
  end

  // register bus state; readies rest high
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      {aw_r, w_r, bv_r} <= 3'h0;
      {ar_r, rv_r, rpend_r} <= 3'h0;
      {awrdy_r, wrdy_r, arrdy_r} <= 3'h7;
      {awa_r, ara_r, ridx_r} <= 28'h0000000;
      {wd_r, rd_r} <= 64'h0000000000000000;
      {bresp_r, rresp_r, wsz_r} <= 5'h00;
    end else begin
      {aw_r, w_r, bv_r} <= {aw_nxt, w_nxt, bv_nxt};
      {ar_r, rv_r, rpend_r} <= {ar_nxt, rv_nxt, rpend_nxt};
      {awrdy_r, wrdy_r, arrdy_r} <= {awrdy_nxt, wrdy_nxt, arrdy_nxt};
      {awa_r, ara_r, ridx_r} <= {awa_nxt, ara_nxt, ridx_nxt};
      {wd_r, rd_r} <= {wd_nxt, rd_nxt};
      {bresp_r, rresp_r, wsz_r} <= {bresp_nxt, rresp_nxt, wsz_nxt};
    end
  end
  // timer, capture, status and pin sample state
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      {mode_r, rev_cap_r, outc_r} <= 8'h00;
      {ccra_r, ccrb_r} <= {`TCG_RST_CCR, `TCG_RST_CCR};
      {cnt_r, presc_r} <= {16'h0000, `TCG_RST_PRESC};
      {stat_r, mask_r, edge_r} <= 12'h000;
      {pa_r, pb_r, a_s_r, b_s_r} <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      {mode_r, rev_cap_r, outc_r} <= {mode_nxt, rev_cap_nxt, outc_nxt};
      {ccra_r, ccrb_r} <= {ccra_nxt, ccrb_nxt};
      {cnt_r, presc_r} <= {cnt_nxt, presc_nxt};
      {stat_r, mask_r, edge_r} <= {stat_nxt, mask_nxt, edge_nxt};
      {pa_r, pb_r, a_s_r, b_s_r} <= {pa_nxt, pb_nxt, pa_r, pb_r};
      irq_r <= irq_nxt;
    end
  end
  // one-shot and output pin state
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      os_r <= tcg_pkg::TCG_OS_IDLE;
      {tout_r, oe_r} <= 2'b00;
    end else begin
      os_r <= os_nxt;
      {tout_r, oe_r} <= {tout_nxt, oe_nxt};
    end
  end
  // outputs straight from flops
  assign AWREADY_O = awrdy_r;
  assign WREADY_O = wrdy_r;
  assign BVALID_O = bv_r;
  assign BRESP_O = bresp_r;
  assign ARREADY_O = arrdy_r;
  assign RVALID_O = rv_r;
  assign RDATA_O = rd_r;
  assign RRESP_O = rresp_r;
  assign TIMER_OUT_O = tout_r;
  assign TIMER_OUT_OE_O = oe_r;
  assign IRQ_O = irq_r;
endmodule

//--- tcg_chk.sv
`timescale 1ns/1ps
// bus handshake checks seen at the top ports
module tcg_chk (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // write channels
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic [1:0] BRESP_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  // read channels
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  // request acceptance steps
  sequence s_ar_taken;
    ARVALID_I && ARREADY_O;
  endsequence
  sequence s_wr_taken;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  // answers come at a fixed distance from acceptance
  property p_read_answer;
    s_ar_taken |-> ##3 RVALID_O;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer off time");
  property p_read_busy;
    s_ar_taken |=> !ARREADY_O [*3];
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("read address open while busy");
  property p_write_answer;
    s_wr_taken |-> ##2 BVALID_O;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer off time");
  // a pending response blocks new writes and holds steady
  property p_write_busy;
    BVALID_O |-> !AWREADY_O && !WREADY_O;
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("write open while answer pending");
  property p_b_hold;
    BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped or changed");
  property p_r_hold;
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped or changed");
endmodule
bind tcg_top tcg_chk u_chk (
  .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
  .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
  .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
  .RVALID_O(RVALID_O), .RREADY_I(RREADY_I)
);

//--- tcg_pulse_src.sv
`timescale 1ns/1ps
// external pulse source on the two capture pins
module tcg_pulse_src #(parameter int WIDTH = 16) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pulse requests
  input wire logic fire_a_i,
  input wire logic fire_b_i,
  // pin levels
  output logic level_a_o,
  output logic level_b_o
);
  int cnt_a;
  int cnt_b;
  // each pulse outlasts two count ticks; pins rest low otherwise
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_a <= 0;
      cnt_b <= 0;
    end else begin
      cnt_a <= fire_a_i ? WIDTH : ((cnt_a > 0) ? cnt_a - 1 : 0);
      cnt_b <= fire_b_i ? WIDTH : ((cnt_b > 0) ? cnt_b - 1 : 0);
    end
  end
  assign level_a_o = (cnt_a > 0); // steady unless asked
  assign level_b_o = (cnt_b > 0);
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "tcg_consts.svh"
// register-level checks of the timer through its bus
module tb_top;
  logic CLOCK_I, RST_B_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
  logic [11:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O;
  logic [1:0] BRESP_O, RRESP_O;
  logic [3:0] WSTRB_I;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic cap_a, cap_b, fire_a, fire_b, TIMER_OUT_O, TIMER_OUT_OE_O, IRQ_O;
  int failures;
  int compares;
  tcg_top DUT (
    .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .CAPTURE_INPUT_A_I(cap_a), .CAPTURE_INPUT_B_I(cap_b), .TIMER_OUT_O(TIMER_OUT_O),
    .TIMER_OUT_OE_O(TIMER_OUT_OE_O), .IRQ_O(IRQ_O)
  );
  tcg_pulse_src u_src (
    .clk_i(CLOCK_I), .rst_b_i(RST_B_I), .fire_a_i(fire_a), .fire_b_i(fire_b),
    .level_a_o(cap_a), .level_b_o(cap_b)
  );
  // verdict and end of run
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tmo();
    failures++;
    summarize();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait on the interrupt (0) or the timer output (1)
  task automatic wait_for(input int s, input logic v);
    int n;
    for (n = 0; n < 1000; n++) begin
      @(posedge CLOCK_I);
      if (((s == 0) ? IRQ_O : TIMER_OUT_O) === v) return;
    end
    tmo();
  endtask
  // bus write; the response is stalled a little
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge CLOCK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLOCK_I);
      if (BVALID_O === 1'b1 && BREADY_I === 1'b1) break;
      if (AWREADY_O === 1'b1) AWVALID_I <= 1'b0;
      if (WREADY_O === 1'b1) WVALID_I <= 1'b0;
      BREADY_I <= (n >= 3);
    end
    BREADY_I <= 1'b0;
    if (n >= 100) tmo();
    chk("bresp", 32'(BRESP_O), 32'(er));
  endtask
  // bus read compared under a mask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    int n;
    @(posedge CLOCK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLOCK_I);
      if (RVALID_O === 1'b1 && RREADY_I === 1'b1) break;
      if (ARREADY_O === 1'b1) ARVALID_I <= 1'b0;
      RREADY_I <= (n >= 4);
    end
    RREADY_I <= 1'b0;
    if (n >= 100) tmo();
    chk("rresp", 32'(RRESP_O), 32'(er));
    chk("rdata", RDATA_O & m, e);
  endtask
  task automatic pulse(input logic on_b);
    @(posedge CLOCK_I);
    fire_a <= !on_b;
    fire_b <= on_b;
    @(posedge CLOCK_I);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
  endtask
  // clock
  initial begin
    CLOCK_I = 1'b0;
    forever #2.5 CLOCK_I = ~CLOCK_I;
  end
  // main sequence
  initial begin
    failures = 0;
    compares = 0;
    RST_B_I = 1'b0;
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, fire_a, fire_b} = 7'h00;
    AWADDR_I = 12'h000;
    ARADDR_I = 12'h000;
    WDATA_I = 32'h00000000;
    WSTRB_I = 4'hF;
    repeat (8) @(posedge CLOCK_I);
    RST_B_I <= 1'b1;
    rd(`TCG_OFF_CCRA, 32'h0000FFFF, 32'hFFFFFFFF, 2'b00);
    rd(`TCG_OFF_MASK, 32'h00000000, 32'hFFFFFFFF, 2'b00);
    rd(12'h020, 32'h00000000, 32'hFFFFFFFF, 2'b10);
    wr(12'h030, 32'h00000001, 2'b10);
    wr(`TCG_OFF_EDGE, 32'h00000005, 2'b00); // edges picked while stopped
    wr(`TCG_OFF_CCRA, 32'h00000040, 2'b00);
    wr(`TCG_OFF_CCRB, 32'h00000020, 2'b00);
    // an empty strobe is answered with an error
    WSTRB_I <= 4'h0;
    wr(`TCG_OFF_MASK, 32'h00000003, 2'b10);
    WSTRB_I <= 4'hF;
    wr(`TCG_OFF_MASK, 32'h00000003, 2'b00);
    wr(`TCG_OFF_OUTC, 32'h00000018, 2'b00);
    wr(`TCG_OFF_OUTC, 32'h00000019, 2'b00);
    wr(`TCG_OFF_OUTC, 32'h0000001D, 2'b00);
    repeat (3) @(posedge CLOCK_I);
    chk("oe", 32'(TIMER_OUT_OE_O), 32'h1);
    chk("out", 32'(TIMER_OUT_O), 32'h0);
    // start, then fire the one-shot from software only
    wr(`TCG_OFF_CTRL, 32'h00000009, 2'b00);
    wr(`TCG_OFF_CTRL, 32'h0000000D, 2'b00); // pin A held steady
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    // valid edge on A interrupts, the trailing reverse edge stays silent
    pulse(1'b0);
    wait_for(0, 1'b1);
    rd(`TCG_OFF_STAT, 32'h00000001, 32'h00000003, 2'b00);
    wait_for(0, 1'b0);
    rd(`TCG_OFF_CCRA, 32'h00000040, 32'h0000FFFC, 2'b00); // read after interrupt
    repeat (40) @(posedge CLOCK_I);
    rd(`TCG_OFF_STAT, 32'h00000000, 32'h00000001, 2'b00);
    chk("irq", 32'(IRQ_O), 32'h0);
    // the trailing falling edge still captured, a few ticks later
    rd(`TCG_OFF_CCRA, 32'h00000044, 32'h0000FFFC, 2'b00);
    pulse(1'b1);
    wait_for(0, 1'b1);
    rd(`TCG_OFF_STAT, 32'h00000002, 32'h00000003, 2'b00);
    // stopping leaves the compare registers at their idle value
    wr(`TCG_OFF_CTRL, 32'h00000000, 2'b00);
    rd(`TCG_OFF_CCRA, 32'h0000FFFF, 32'hFFFFFFFF, 2'b00);
    rd(`TCG_OFF_CCRB, 32'h0000FFFF, 32'hFFFFFFFF, 2'b00);
    summarize();
  end
endmodule
